// ### hw/quad_divider.sv
// Purpose: divides encoder feedback counts into A/B/Z output pulses
// Assumes: step_i is one pulse per encoder count, dir_i high forward
// Notes:   outputs registered; at most one quadrature step per count
`include "servo_status_map.svh"
module quad_divider import servo_status_pkg::*; #(
	parameter int ENC_CPR = `ENC_CPR_DEF
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         step_i,
	input  wire logic         dir_i,
	input  wire logic         rev_i,
	input  wire logic [15:0]  ppr_i,
	input  wire logic [15:0]  z_ofs_i,
	output quad_out_type      quad_o
);

	localparam logic [17:0] CPR_V = 18'(ENC_CPR);

	logic [15:0]  n;
	logic [17:0]  n4;
	logic [17:0]  acc_q, acc_d, acc_sum;
	logic [16:0]  pos_q, pos_d, lim;
	logic [16:0]  tgt_q, tgt_d;
	logic         ld_q;
	logic         adv, a, b, z;
	quad_out_type out_q, out_d;

	// ----------------------------------------
	// accumulate and step
	// ----------------------------------------
	always_comb begin
		if (ppr_i < `PPR_MIN)
			n = `PPR_MIN;
		else if (ppr_i > `PPR_MAX)
			n = `PPR_MAX;
		else
			n = ppr_i;
		n4 = {n, 2'b00};
		lim = 17'(n4 - 18'h0_0001);
		acc_sum = acc_q + n4;
		adv = step_i && (acc_sum >= CPR_V);
		acc_d = acc_q;
		pos_d = pos_q;
		if (step_i)
			acc_d = adv ? 18'(acc_sum - CPR_V) : acc_sum;
		if (adv) begin
			if (dir_i)
				pos_d = (pos_q >= lim) ? 17'h0_0000 : 17'(pos_q + 17'h0_0001);
			else
				pos_d = (pos_q == 17'h0_0000) ? lim : 17'(pos_q - 17'h0_0001);
		end
		// index target is twice the offset, reduced modulo the pulse count
		tgt_d = tgt_q;
		if (ld_q)
			tgt_d = {z_ofs_i, 1'b0};
		else if (tgt_q >= {1'b0, n})
			tgt_d = 17'(tgt_q - {1'b0, n});
		a = pos_d[1];
		b = pos_d[1] ^ pos_d[0];
		z = (pos_d[16:2] == tgt_q[14:0]) && a;
		out_d.a = a;
		out_d.a_n = ~a;
		out_d.b = rev_i ? ~b : b;
		out_d.b_n = rev_i ? b : ~b;
		out_d.z_n = ~z;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_q <= 18'h0_0000;
			pos_q <= 17'h0_0000;
			tgt_q <= 17'h0_0000;
			ld_q <= 1'b1;
			out_q <= 5'b0_1011;
		end else begin
			acc_q <= acc_d;
			pos_q <= pos_d;
			tgt_q <= tgt_d;
			ld_q <= 1'b0;
			out_q <= out_d;
		end
	end

	assign quad_o = out_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_quad_gray;
		@(posedge clk_i) disable iff (rst_i)
		($changed(out_q.a) && $stable(rev_i)) |-> $stable(out_q.b);
	endproperty
	a_quad_gray: assert property (p_quad_gray) else $error("a and b moved together");

	property p_index_on_a;
		@(posedge clk_i) disable iff (rst_i)
		!out_q.z_n |-> out_q.a;
	endproperty
	a_index_on_a: assert property (p_index_on_a) else $error("index outside a high");

	c_index: cover property (@(posedge clk_i) disable iff (rst_i) $fell(out_q.z_n));

endmodule

// ### hw/servo_status_and_encoder_divider.sv
// Purpose: brake timing, sequence outputs, position status and pulse divider
// Assumes: settings are steady levels; feedback steps are one-cycle pulses
// Notes:   all outputs are registered; long counts are parameters
`include "servo_status_map.svh"
module servo_status_and_encoder_divider import servo_status_pkg::*; #(
	parameter int POS_W    = 32,
	parameter int MS_CYC   = `MS_TICK_CYC,
	parameter int ENC_CPR  = `ENC_CPR_DEF
) (
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RST_I,
	// servo sequence
	input  wire logic              SERVO_ON_I,
	input  wire logic              ALARM_I,
	input  wire logic              ALARM_CLR_I,
	input  wire logic              POS_MODE_I,
	// settings
	input  wire logic [3:0][7:0]   OUT_ASSIGN_I,
	input  wire logic [9:0]        BRAKE_TIME_I,
	input  wire logic [15:0]       PPR_I,
	input  wire logic [15:0]       Z_OFFSET_I,
	input  wire logic              DIR_SWITCH_I,
	input  wire logic [14:0]       ZD_WIDTH_I,
	input  wire logic [15:0]       DL_WIDTH_I,
	input  wire logic [12:0]       ZS_WIDTH_I,
	input  wire logic [9:0]        JUDGE_MS_I,
	// feedback
	input  wire logic              FB_STEP_I,
	input  wire logic              FB_DIR_I,
	input  wire logic [POS_W-1:0]  CMD_POS_I,
	input  wire logic [POS_W-1:0]  FB_POS_I,
	input  wire logic [15:0]       SPEED_I,
	// sequence outputs
	output logic [3:0]             SEQ_OUT_O,
	output logic                   BRAKE_TIMING_O,
	output logic                   MOTOR_DRIVE_O,
	output status_type             STATUS_O,
	// divided pulse outputs
	output quad_out_type           QUAD_O
);

	localparam logic [16:0] MS_LAST = 17'(MS_CYC - 1);

	// ----------------------------------------
	// time base
	// ----------------------------------------
	logic [16:0] ms_cnt_q, ms_cnt_d;
	logic [3:0]  ten_cnt_q, ten_cnt_d;
	logic        ms_tick, step_tick;

	always_comb begin
		ms_tick = (ms_cnt_q == MS_LAST);
		ms_cnt_d = ms_tick ? 17'h0_0000 : 17'(ms_cnt_q + 17'h0_0001);
		ten_cnt_d = ten_cnt_q;
		if (ms_tick)
			ten_cnt_d = (ten_cnt_q == `BRAKE_STEP_MS) ? 4'h0 : 4'(ten_cnt_q + 4'h1);
		step_tick = ms_tick && (ten_cnt_q == `BRAKE_STEP_MS);
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ms_cnt_q <= 17'h0_0000;
			ten_cnt_q <= 4'h0;
		end else begin
			ms_cnt_q <= ms_cnt_d;
			ten_cnt_q <= ten_cnt_d;
		end
	end

	// ----------------------------------------
	// position and speed status
	// ----------------------------------------
	logic signed [POS_W:0] diff;
	logic [POS_W:0]        dev_abs;
	logic [22:0]           dl_pulses;
	logic [15:0]           spd_abs;
	logic                  zd_d, zs_d, over_lim;
	logic                  zd_q, zs_q, dal_q, dal_d;
	logic [9:0]            jcnt_q, jcnt_d;
	logic                  pend_q, pend_d;

	always_comb begin
		diff = $signed({CMD_POS_I[POS_W-1], CMD_POS_I})
			- $signed({FB_POS_I[POS_W-1], FB_POS_I});
		dev_abs = diff[POS_W] ? (POS_W+1)'(-diff) : diff;
		dl_pulses = 23'(DL_WIDTH_I * `DEV_LIM_UNIT);
		spd_abs = SPEED_I[15] ? 16'(-SPEED_I) : SPEED_I;
		// outside position mode zero deviation stays on
		zd_d = !POS_MODE_I || (dev_abs <= (POS_W+1)'(ZD_WIDTH_I));
		zs_d = (spd_abs <= {3'b000, ZS_WIDTH_I});
		over_lim = POS_MODE_I && (dev_abs >= (POS_W+1)'(dl_pulses));
		// a new excess wins over a clear in the same cycle
		dal_d = over_lim || (dal_q && !ALARM_CLR_I);
		jcnt_d = jcnt_q;
		pend_d = 1'b0;
		if (!(zd_q && zs_q && POS_MODE_I))
			jcnt_d = 10'h000;
		else if (jcnt_q >= JUDGE_MS_I)
			pend_d = 1'b1;
		else if (ms_tick)
			jcnt_d = 10'(jcnt_q + 10'h001);
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			zd_q <= 1'b1;
			zs_q <= 1'b1;
			dal_q <= 1'b0;
			jcnt_q <= 10'h000;
			pend_q <= 1'b0;
		end else begin
			zd_q <= zd_d;
			zs_q <= zs_d;
			dal_q <= dal_d;
			jcnt_q <= jcnt_d;
			pend_q <= pend_d;
		end
	end

	// ----------------------------------------
	// brake sequencer
	// ----------------------------------------
	brake_state_type st_q, st_d;
	logic [9:0]      bcnt_q, bcnt_d;
	logic            alarm_any, assigned;
	logic            brk_d, brk_q, drv_d, drv_q;

	always_comb begin
		alarm_any = ALARM_I || dal_q;
		assigned = 1'b0;
		for (int k = 0; k < 4; k++)
			if (OUT_ASSIGN_I[k] == `FN_BRAKE)
				assigned = 1'b1;
		st_d = st_q;
		bcnt_d = bcnt_q;
		case (st_q)
			ST_IDLE: begin
				if (alarm_any)
					st_d = ST_ALARM;
				else if (SERVO_ON_I)
					st_d = ST_RUN;
			end
			ST_RUN: begin
				bcnt_d = 10'h000;
				if (alarm_any)
					st_d = ST_ALARM;
				else if (!SERVO_ON_I)
					st_d = ST_HOLD;
			end
			ST_HOLD: begin
				// drive stays on until the brake has had time to bite
				if (alarm_any)
					st_d = ST_ALARM;
				else if (SERVO_ON_I)
					st_d = ST_RUN;
				else if (bcnt_q >= BRAKE_TIME_I)
					st_d = ST_IDLE;
				else if (step_tick)
					bcnt_d = 10'(bcnt_q + 10'h001);
			end
			ST_ALARM: begin
				if (!alarm_any)
					st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
		brk_d = (st_d == ST_RUN) && assigned;
		drv_d = (st_d == ST_RUN) || (st_d == ST_HOLD);
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			st_q <= ST_IDLE;
			bcnt_q <= 10'h000;
			brk_q <= 1'b0;
			drv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			bcnt_q <= bcnt_d;
			brk_q <= brk_d;
			drv_q <= drv_d;
		end
	end

	// ----------------------------------------
	// sequence output terminals
	// ----------------------------------------
	logic [3:0] seq_d, seq_q;

	for (genvar g = 0; g < 4; g++) begin : g_term
		always_comb begin
			case (OUT_ASSIGN_I[g])
				`FN_BRAKE:      seq_d[g] = brk_d;
				`FN_ZERO_DEV:   seq_d[g] = zd_d;
				`FN_ZERO_SPEED: seq_d[g] = zs_d;
				default:        seq_d[g] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I)
			seq_q <= 4'h0;
		else
			seq_q <= seq_d;
	end

	// ----------------------------------------
	// divided pulse output
	// ----------------------------------------
	quad_divider #(
		.ENC_CPR (ENC_CPR)
	) u_div (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.step_i  (FB_STEP_I),
		.dir_i   (FB_DIR_I),
		.rev_i   (DIR_SWITCH_I),
		.ppr_i   (PPR_I),
		.z_ofs_i (Z_OFFSET_I),
		.quad_o  (QUAD_O)
	);

	assign SEQ_OUT_O = seq_q;
	assign BRAKE_TIMING_O = brk_q;
	assign MOTOR_DRIVE_O = drv_q;
	assign STATUS_O = '{zero_dev: zd_q, zero_speed: zs_q, pos_end: pend_q, dev_alarm: dal_q};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	property p_servo_off;
		!SERVO_ON_I |=> !BRAKE_TIMING_O;
	endproperty
	a_servo_off: assert property (p_servo_off) else $error("brake timing without servo on");

	property p_route;
		OUT_ASSIGN_I[0] == `FN_BRAKE |=> SEQ_OUT_O[0] == BRAKE_TIMING_O;
	endproperty
	a_route: assert property (p_route) else $error("terminal one not brake timing");

	property p_unassigned;
		!assigned |=> !BRAKE_TIMING_O;
	endproperty
	a_unassigned: assert property (p_unassigned) else $error("unassigned brake timing active");

	property p_hold_drive;
		(st_q == ST_RUN && !SERVO_ON_I && !alarm_any && BRAKE_TIME_I != 10'h000)
			|=> (MOTOR_DRIVE_O && !BRAKE_TIMING_O);
	endproperty
	a_hold_drive: assert property (p_hold_drive) else $error("drive dropped before brake time");

	property p_alarm;
		alarm_any |=> (!BRAKE_TIMING_O && !MOTOR_DRIVE_O);
	endproperty
	a_alarm: assert property (p_alarm) else $error("brake timing on under alarm");

	property p_zero_dev_mode;
		!POS_MODE_I |=> STATUS_O.zero_dev;
	endproperty
	a_zero_dev_mode: assert property (p_zero_dev_mode) else $error("zero deviation dropped");

	property p_zero_speed;
		(!SPEED_I[15] && (SPEED_I <= {3'b000, ZS_WIDTH_I})) |=> STATUS_O.zero_speed;
	endproperty
	a_zero_speed: assert property (p_zero_speed) else $error("zero speed missed");

	property p_pos_end;
		!(STATUS_O.zero_dev && STATUS_O.zero_speed && POS_MODE_I) |=> !STATUS_O.pos_end;
	endproperty
	a_pos_end: assert property (p_pos_end) else $error("positioning end too early");

	property p_dev_limit;
		over_lim |=> STATUS_O.dev_alarm ##1 !BRAKE_TIMING_O;
	endproperty
	a_dev_limit: assert property (p_dev_limit) else $error("deviation limit not raised");

	c_hold: cover property (st_q == ST_HOLD ##1 st_q == ST_IDLE);
	c_pos_end: cover property ($rose(STATUS_O.pos_end));
	c_alarm: cover property (BRAKE_TIMING_O ##1 alarm_any ##1 !BRAKE_TIMING_O);

endmodule

// ### hw/servo_status_map.svh
// Purpose: constants for the servo status and encoder divider block
// Assumes: 100 MHz CLK_I, synchronous active-high reset
// Notes:   times are in their own unit; cycle counts are derived from them
`ifndef SERVO_STATUS_MAP_SVH
`define SERVO_STATUS_MAP_SVH

`define FN_ZERO_DEV    8'h08
`define FN_ZERO_SPEED  8'h09
`define FN_BRAKE       8'h0b

`define CLK_PERIOD_NS  10
`define MS_TICK_NS     1000000
`define MS_TICK_CYC    (`MS_TICK_NS / `CLK_PERIOD_NS)
`define BRAKE_STEP_MS  4'h9

`define PPR_MIN        16'h0010
`define PPR_MAX        16'h8000
`define ENC_CPR_DEF    131072
`define DEV_LIM_UNIT   7'h64

`endif

// ### hw/servo_status_pkg.sv
// Purpose: shared types of the servo status and encoder divider block
// Assumes: nothing beyond the map header
// Notes:   one-hot brake sequencer states
package servo_status_pkg;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_RUN   = 4'b0010,
		ST_HOLD  = 4'b0100,
		ST_ALARM = 4'b1000
	} brake_state_type;

	typedef struct packed {
		logic a;
		logic a_n;
		logic b;
		logic b_n;
		logic z_n;
	} quad_out_type;

	typedef struct packed {
		logic zero_dev;
		logic zero_speed;
		logic pos_end;
		logic dev_alarm;
	} status_type;

endpackage

// ### verif/pulse_counter_model.sv
// Purpose: controller model counting the divided pulses
// Assumes: sampled on the device clock, cleared in reset
// Notes:   position moves on each rise of A, sign from B
module pulse_counter_model import servo_status_pkg::*; (
	// device side
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire quad_out_type  quad_i,
	// counts
	output logic signed [15:0] pos_o,
	output logic [7:0]         zc_o,
	output logic               bad_o
);
	timeunit 1ns;
	timeprecision 100ps;
	quad_out_type prev;
	// sampling every clock, far above 500 kHz
	always @(posedge clk_i) begin
		if (rst_i) begin
			pos_o <= '0;
			zc_o <= '0;
			bad_o <= 1'b0;
			prev <= 5'b01011;
		end else begin
			if (quad_i.a && !prev.a)
				pos_o <= quad_i.b ? pos_o + 16'sd1 : pos_o - 16'sd1;
			if (!quad_i.z_n && prev.z_n)
				zc_o <= zc_o + 8'h01;
			if (quad_i.a_n !== ~quad_i.a || quad_i.b_n !== ~quad_i.b)
				bad_o <= 1'b1;
			if (quad_i.z_n === 1'b0 && quad_i.a !== 1'b1)
				bad_o <= 1'b1;
			prev <= quad_i;
		end
	end
endmodule

// ### verif/tb_servo_status_and_encoder_divider.sv
// Purpose: self-checking bench of the status and divider block
// Assumes: 1 ms shortened to 10 cycles, 64 counts per revolution
// Notes:   table rows first, then the sequencer and divider cases
`include "servo_status_map.svh"
module tb_servo_status_and_encoder_divider import servo_status_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK_I = 0, RST_I = 1, SERVO_ON_I = 0, ALARM_I = 0, ALARM_CLR_I = 0;
	logic POS_MODE_I = 1, DIR_SWITCH_I = 0, FB_STEP_I = 0, FB_DIR_I = 1;
	logic [3:0][7:0] OUT_ASSIGN_I = {8'h00, `FN_BRAKE, `FN_ZERO_SPEED, `FN_ZERO_DEV};
	logic [9:0] BRAKE_TIME_I = '0, JUDGE_MS_I = 10'h002;
	logic [15:0] PPR_I = `PPR_MIN, Z_OFFSET_I = '0, DL_WIDTH_I = 16'h000a;
	logic [15:0] SPEED_I = '0;
	logic [14:0] ZD_WIDTH_I = 15'h0190;
	logic [12:0] ZS_WIDTH_I = 13'h0032;
	logic [31:0] CMD_POS_I = '0, FB_POS_I = '0;
	logic [3:0] SEQ_OUT_O;
	logic BRAKE_TIMING_O, MOTOR_DRIVE_O, bad;
	status_type STATUS_O;
	quad_out_type QUAD_O;
	logic signed [15:0] pos;
	logic [7:0] zc;
	int err_count = 0, check_count = 0, cyc = 0;
	typedef struct {logic pm; int cmd; int fb; int spd; logic zd; logic zs;} row_type;
	row_type rows[4] = '{'{1, 400, 0, 50, 1, 1}, '{1, 401, 0, 51, 0, 0},
		'{0, 401, 0, 0, 1, 1}, '{1, 0, 400, 10, 1, 1}};

	always #5 CLK_I = ~CLK_I;

	servo_status_and_encoder_divider #(.MS_CYC(10), .ENC_CPR(64))
	i_servo_status_and_encoder_divider (.CLK_I(CLK_I), .RST_I(RST_I),
		.SERVO_ON_I(SERVO_ON_I), .ALARM_I(ALARM_I), .ALARM_CLR_I(ALARM_CLR_I),
		.POS_MODE_I(POS_MODE_I), .OUT_ASSIGN_I(OUT_ASSIGN_I),
		.BRAKE_TIME_I(BRAKE_TIME_I), .PPR_I(PPR_I), .Z_OFFSET_I(Z_OFFSET_I),
		.DIR_SWITCH_I(DIR_SWITCH_I), .ZD_WIDTH_I(ZD_WIDTH_I),
		.DL_WIDTH_I(DL_WIDTH_I), .ZS_WIDTH_I(ZS_WIDTH_I), .JUDGE_MS_I(JUDGE_MS_I),
		.FB_STEP_I(FB_STEP_I), .FB_DIR_I(FB_DIR_I), .CMD_POS_I(CMD_POS_I),
		.FB_POS_I(FB_POS_I), .SPEED_I(SPEED_I), .SEQ_OUT_O(SEQ_OUT_O),
		.BRAKE_TIMING_O(BRAKE_TIMING_O), .MOTOR_DRIVE_O(MOTOR_DRIVE_O),
		.STATUS_O(STATUS_O), .QUAD_O(QUAD_O));

	pulse_counter_model i_pulse_counter_model (.clk_i(CLK_I), .rst_i(RST_I),
		.quad_i(QUAD_O), .pos_o(pos), .zc_o(zc), .bad_o(bad));

	task tick(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask

	task chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task steps(input int n);
		repeat (n) begin
			FB_STEP_I = 1'b1;
			tick(1);
			FB_STEP_I = 1'b0;
			tick(1);
		end
	endtask

	task conclude;
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			conclude;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tick(2);
		chk(STATUS_O === 4'b1100 && QUAD_O === 5'b01011, "reset flags");
		chk(SEQ_OUT_O === 4'h0 && {BRAKE_TIMING_O, MOTOR_DRIVE_O} === 2'b00, "reset");
		RST_I = 0;
		foreach (rows[i]) begin
			POS_MODE_I = rows[i].pm;
			CMD_POS_I = rows[i].cmd;
			FB_POS_I = rows[i].fb;
			SPEED_I = rows[i].spd[15:0];
			tick(3);
			chk(STATUS_O.zero_dev === rows[i].zd, "zero deviation");
			chk(STATUS_O.zero_speed === rows[i].zs, "zero speed");
			chk(SEQ_OUT_O[1:0] === {rows[i].zs, rows[i].zd}, "terminals");
		end
		for (int k = 0; k < 5; k++) begin
			OUT_ASSIGN_I = 32'h0000_000b << (8 * k);
			SERVO_ON_I = 1;
			tick(3);
			chk(SEQ_OUT_O === 4'(32'h1 << k), "brake terminal");
			chk(BRAKE_TIMING_O === (k < 4) && MOTOR_DRIVE_O === 1'b1, "on");
			SERVO_ON_I = 0;
			tick(3);
			chk({BRAKE_TIMING_O, MOTOR_DRIVE_O} === 2'b00, "off");
		end
		OUT_ASSIGN_I = {8'h00, `FN_BRAKE, `FN_ZERO_SPEED, `FN_ZERO_DEV};
		BRAKE_TIME_I = 10'h002;
		SERVO_ON_I = 1;
		tick(3);
		SERVO_ON_I = 0;
		tick(2);
		chk(BRAKE_TIMING_O === 1'b0 && MOTOR_DRIVE_O === 1'b1, "hold");
		tick(93);
		chk(MOTOR_DRIVE_O === 1'b1, "drive held");
		tick(220);
		chk(MOTOR_DRIVE_O === 1'b0, "drive released");
		// alarm while running drops brake timing; it returns once the alarm clears
		SERVO_ON_I = 1;
		tick(3);
		ALARM_I = 1;
		tick(2);
		chk(BRAKE_TIMING_O === 1'b0, "alarm brake");
		ALARM_I = 0;
		tick(4);
		chk(BRAKE_TIMING_O === 1'b1, "alarm gone");
		POS_MODE_I = 0;
		FB_POS_I = 0;
		CMD_POS_I = 1000;
		tick(3);
		chk(STATUS_O.dev_alarm === 1'b0, "limit off mode");
		POS_MODE_I = 1;
		CMD_POS_I = 999;
		tick(3);
		chk(STATUS_O.dev_alarm === 1'b0, "below limit");
		CMD_POS_I = 1000;
		tick(3);
		chk(STATUS_O.dev_alarm === 1'b1 && BRAKE_TIMING_O === 1'b0, "limit");
		CMD_POS_I = 0;
		ALARM_CLR_I = 1;
		tick(2);
		ALARM_CLR_I = 0;
		tick(4);
		chk(STATUS_O.dev_alarm === 1'b0 && BRAKE_TIMING_O === 1'b1, "cleared");
		SPEED_I = 16'h0064;
		tick(3);
		chk(STATUS_O.pos_end === 1'b0, "moving");
		SPEED_I = 16'h0000;
		tick(8);
		chk(STATUS_O.pos_end === 1'b0, "judging");
		tick(30);
		chk(STATUS_O.pos_end === 1'b1, "positioned");
		SPEED_I = 16'h0064;
		tick(3);
		chk(STATUS_O.pos_end === 1'b0, "end dropped");
		steps(64);
		tick(3);
		chk(pos === 16'sd16 && zc === 8'h01, "forward rev");
		DIR_SWITCH_I = 1;
		tick(2);
		steps(64);
		tick(3);
		chk(pos === 16'sd0 && zc === 8'h02, "switched rev");
		chk(bad === 1'b0, "quadrature form");
		// index offset is taken at reset release: 3 units put the index at pulse 6
		RST_I = 1;
		Z_OFFSET_I = 16'h0003;
		tick(2);
		chk(QUAD_O === 5'b01011 && MOTOR_DRIVE_O === 1'b0, "second reset");
		RST_I = 0;
		tick(2);
		steps(25);
		tick(3);
		chk(zc === 8'h00 && pos === -16'sd6, "before offset index");
		steps(1);
		tick(3);
		chk(zc === 8'h01 && pos === -16'sd7, "offset index");
		// home search at low speed runs past 376 degrees: 67 of 64 counts
		steps(41);
		tick(3);
		chk(zc === 8'h01 && bad === 1'b0, "one index per turn");
		conclude;
	end
endmodule
